// ==== cebf_pkg.sv ====
// Package for the comparator event and blanking filter block
package cebf_pkg;
  // Register byte addresses on the APB bus
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_MSRC = 12'h004;
  localparam logic [11:0] ADDR_MGATE = 12'h008;
  localparam logic [11:0] ADDR_FILT = 12'h00C;
  localparam logic [11:0] ADDR_ISTAT = 12'h010;
  localparam logic [11:0] ADDR_IMASK = 12'h014;
  // Control register fields
  localparam int CTRL_ENABLE = 15;
  localparam int CTRL_OE = 14;
  localparam int CTRL_INV = 13;
  localparam int CTRL_EVT = 9;
  localparam int CTRL_OUT = 8;
  localparam int CTRL_EDGE_LO = 6;
  localparam int CTRL_PLUS = 4;
  localparam int CTRL_MINUS_LO = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hE0D3;
  localparam logic [15:0] MSRC_WMASK = 16'h0FFF;
  localparam logic [15:0] MGATE_WMASK = 16'hBFFF;
  localparam logic [15:0] FILT_WMASK = 16'h007F;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Gate control fields
  localparam int MG_LEVEL = 15;
  localparam int MG_OR_LO = 8;
  localparam int MG_NAND = 7;
  localparam int MG_PAND = 6;
  localparam int MG_AND_LO = 0;
  // Filter fields
  localparam int FT_SRC_LO = 4;
  localparam int FT_EN = 3;
  localparam int FT_DIV_LO = 0;
  localparam int FILT_COUNT_W = 7;
  localparam logic [2:0] FILT_SAMPLES = 3'h3;
  // Event edge codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  // Filter clock source codes
  localparam logic [2:0] FSRC_PCLK = 3'h0;
  localparam logic [2:0] FSRC_OSC = 3'h1;
  localparam logic [2:0] FSRC_SYNC = 3'h2;
  localparam logic [2:0] FSRC_T2 = 3'h4;
  // Input mux codes and source group bounds
  localparam logic [1:0] MINUS_PIN = 2'h0;
  localparam logic [3:0] MSRC_PWM_MAX = 4'h5;
  localparam logic [3:0] MSRC_TRIG = 4'hC;
  localparam logic [3:0] MSRC_FAULT_INPUT_2 = 4'hE;
  localparam logic [3:0] MSRC_FAULT_INPUT_4 = 4'hF;
  // Per-package availability of analog sources (bit per source)
  typedef struct packed {
    logic plus_pin;
    logic vref;
    logic minus_pin;
    logic oa1;
    logic oa2;
    logic oa3;
  } cebf_avail_t;
  // Blanking source bundle from PWM, trigger and fault logic
  typedef struct packed {
    logic [5:0] pwm;
    logic trig18;
    logic trig19;
    logic fault2;
    logic fault4;
  } cebf_mask_src_t;
  // Filter clock enable ticks from the rest of the chip
  typedef struct packed {
    logic osc;
    logic sync1;
    logic [3:0] timer;
  } cebf_ticks_t;
  // Analog mux selects toward the comparator core
  typedef struct packed {
    logic plus_sel;
    logic [1:0] minus_sel;
    logic plus_gnd;
    logic minus_gnd;
  } cebf_mux_t;
endpackage

// ==== cebf_block.sv ====
// Comparator four digital conditioning with APB registers
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - Plus select: set picks reference, clear pin
// - Minus select codes pick pin or opamp
// - Missing source on package reads as ground
// - Mask source codes pick PWM, trigger, fault
// - AND gate A true and inverted enables
// - B and C enables; OR gate likewise
// - Filter clock source select codes
// - Filter divider selects power-of-two ratio
// - Event flag sets, blocks events until cleared
// - Edge select: any, falling, rising, off
// - Invert bit inverts result everywhere
// - Pin driven only while output enable set
module cebf_block (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compare_raw,
  input wire cebf_pkg::cebf_avail_t avail,
  input wire cebf_pkg::cebf_mask_src_t mask_src,
  input wire cebf_pkg::cebf_ticks_t ticks,
  output cebf_pkg::cebf_mux_t mux,
  output logic comparator_output_pin,
  output logic comparator_output_pin_oe_n,
  output logic compare_result,
  output logic event_trigger,
  output logic irq
);
  import cebf_pkg::*;

  logic [15:0] ctrl, next_ctrl;
  logic [15:0] msrc, next_msrc;
  logic [15:0] mgate, next_mgate;
  logic [15:0] filt, next_filt;
  logic [1:0] istat, next_istat;
  logic [1:0] imask, next_imask;
  logic [2:0] sync_q, next_sync_q;
  logic [FILT_COUNT_W-1:0] div_cnt, next_div_cnt;
  logic [2:0] filt_hist, next_filt_hist;
  logic filt_out, next_filt_out;
  logic result_q, next_result_q;
  logic evt_pulse, next_evt_pulse;
  logic wr_en, rd_en, addr_ok;
  logic [15:0] wd;
  logic cmp_sync, blanked, adj, src_tick, div_tick, filtered;
  logic mask_a, mask_b, mask_c, and_out, or_out, gate_out;
  logic edge_hit;

  // Picks one blanking source by its four-bit code
  function automatic logic pick_mask(input logic [3:0] code,
                                     input cebf_mask_src_t s);
    logic v;
    v = 1'b0;
    if (code <= MSRC_PWM_MAX) begin
      v = s.pwm[code[2:0]];
    end else begin
      case (code)
        MSRC_TRIG: v = s.trig18;
        MSRC_TRIG + 4'h1: v = s.trig19;
        MSRC_FAULT_INPUT_2: v = s.fault2;
        MSRC_FAULT_INPUT_4: v = s.fault4;
        default: v = 1'b0; // Reserved codes blank nothing
      endcase
    end
    return v;
  endfunction

  // APB decode; zero wait state, so pready is constant high
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wd = pwdata[15:0];
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_MSRC) ||
    (paddr == ADDR_MGATE) || (paddr == ADDR_FILT) ||
    (paddr == ADDR_ISTAT) || (paddr == ADDR_IMASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Analog mux selects, grounded when a source is absent
  always_comb begin
    mux.plus_sel = ctrl[CTRL_PLUS];
    mux.minus_sel = ctrl[CTRL_MINUS_LO +: 2];
    mux.plus_gnd = ctrl[CTRL_PLUS] ? !avail.vref : !avail.plus_pin;
    case (ctrl[CTRL_MINUS_LO +: 2])
      MINUS_PIN: mux.minus_gnd = !avail.minus_pin;
      2'h1: mux.minus_gnd = !avail.oa1;
      2'h2: mux.minus_gnd = !avail.oa2;
      default: mux.minus_gnd = !avail.oa3;
    endcase
  end

  // Blanking gates; the level select says which level is masked
  always_comb begin
    mask_a = pick_mask(msrc[3:0], mask_src);
    mask_b = pick_mask(msrc[7:4], mask_src);
    mask_c = pick_mask(msrc[11:8], mask_src);
    // Unused AND inputs count as one so they do not block the gate
    and_out = (mask_a | !mgate[MG_AND_LO + 1]) &
      (!mask_a | !mgate[MG_AND_LO]) &
      (mask_b | !mgate[MG_AND_LO + 3]) &
      (!mask_b | !mgate[MG_AND_LO + 2]) &
      (mask_c | !mgate[MG_AND_LO + 5]) &
      (!mask_c | !mgate[MG_AND_LO + 4]);
    // An AND with no input enabled reads as zero, so it blanks only through the NAND enable
    if (mgate[5:0] == 6'h00) begin
      and_out = 1'b0;
    end
    or_out = (mask_a & mgate[MG_OR_LO + 1]) | (!mask_a & mgate[MG_OR_LO]) |
      (mask_b & mgate[MG_OR_LO + 3]) | (!mask_b & mgate[MG_OR_LO + 2]) |
      (mask_c & mgate[MG_OR_LO + 5]) | (!mask_c & mgate[MG_OR_LO + 4]);
    gate_out = or_out | (and_out & mgate[MG_PAND]) |
      (!and_out & mgate[MG_NAND]);
    // Blanking holds the output at the level set by MG_LEVEL
    if (gate_out) begin
      blanked = mgate[MG_LEVEL];
    end else begin
      blanked = cmp_sync;
    end
  end

  // Filter clock source and power-of-two divider tick
  always_comb begin
    case (filt[FT_SRC_LO +: 3])
      FSRC_PCLK: src_tick = 1'b1;
      FSRC_OSC: src_tick = ticks.osc;
      FSRC_SYNC: src_tick = ticks.sync1;
      3'h4, 3'h5, 3'h6, 3'h7: src_tick = ticks.timer[filt[FT_SRC_LO +: 2]];
      default: src_tick = 1'b0; // Reserved source stalls the filter
    endcase
    next_div_cnt = div_cnt;
    div_tick = 1'b0;
    if (src_tick) begin
      next_div_cnt = div_cnt + FILT_COUNT_W'(1);
      // Ratio is 2**code, so code 6 gives 1:64 and code 3 gives 1:8
      div_tick = ((div_cnt + FILT_COUNT_W'(1)) &
        ((FILT_COUNT_W'(1) << filt[FT_DIV_LO +: 3]) - FILT_COUNT_W'(1)))
        == '0;
    end
  end

  // Three equal samples in a row on filter ticks move the output
  always_comb begin
    next_filt_hist = filt_hist;
    next_filt_out = filt_out;
    if (div_tick) begin
      next_filt_hist = {filt_hist[1:0], blanked};
      if (filt_hist[1:0] == {2{blanked}}) begin
        next_filt_out = blanked;
      end
    end
    filtered = filt[FT_EN] ? filt_out : blanked;
    adj = ctrl[CTRL_ENABLE] & (filtered ^ ctrl[CTRL_INV]);
    next_result_q = adj;
  end

  // Edge detect on the polarity-adjusted result
  always_comb begin
    case (ctrl[CTRL_EDGE_LO +: 2])
      EDGE_RISE: edge_hit = adj && !result_q;
      EDGE_FALL: edge_hit = !adj && result_q;
      EDGE_ANY: edge_hit = adj != result_q;
      default: edge_hit = 1'b0;
    endcase
    // A set flag locks out further triggers and the event interrupt bit
    next_evt_pulse = edge_hit && !ctrl[CTRL_EVT];
  end

  // Register writes; hardware set of the event flag beats a clear
  always_comb begin
    next_ctrl = ctrl;
    next_msrc = msrc;
    next_mgate = mgate;
    next_filt = filt;
    next_imask = imask;
    next_istat = istat;
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL: next_ctrl = (wd & CTRL_WMASK) | (ctrl & ~CTRL_WMASK);
        ADDR_MSRC: next_msrc = wd & MSRC_WMASK;
        ADDR_MGATE: next_mgate = wd & MGATE_WMASK;
        ADDR_FILT: next_filt = wd & FILT_WMASK;
        ADDR_ISTAT: next_istat = istat & ~wd[1:0];
        ADDR_IMASK: next_imask = wd[1:0];
        default: next_imask = imask;
      endcase
    end
    if (wr_en && paddr == ADDR_CTRL) begin
      next_ctrl[CTRL_EVT] = wd[CTRL_EVT];
    end
    next_ctrl[CTRL_OUT] = adj;
    if (next_evt_pulse) begin
      next_ctrl[CTRL_EVT] = 1'b1;
      next_istat[0] = 1'b1;
    end
    if (adj != result_q) begin
      next_istat[1] = 1'b1;
    end
    next_sync_q = {sync_q[1:0], compare_raw};
  end

  // All state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= REG_RESET;
      msrc <= REG_RESET;
      mgate <= REG_RESET;
      filt <= REG_RESET;
      istat <= 2'h0;
      imask <= 2'h0;
      sync_q <= 3'h0;
      cmp_sync <= 1'b0;
      div_cnt <= '0;
      filt_hist <= 3'h0;
      filt_out <= 1'b0;
      result_q <= 1'b0;
      evt_pulse <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      msrc <= next_msrc;
      mgate <= next_mgate;
      filt <= next_filt;
      istat <= next_istat;
      imask <= next_imask;
      sync_q <= next_sync_q;
      // Change counts only once stages two and three agree
      if (sync_q[1] == sync_q[2]) begin
        cmp_sync <= sync_q[2];
      end
      div_cnt <= next_div_cnt;
      filt_hist <= next_filt_hist;
      filt_out <= next_filt_out;
      result_q <= next_result_q;
      evt_pulse <= next_evt_pulse;
      if (rd_en) begin
        case (paddr)
          ADDR_CTRL: prdata <= {16'h0000, ctrl};
          ADDR_MSRC: prdata <= {16'h0000, msrc};
          ADDR_MGATE: prdata <= {16'h0000, mgate};
          ADDR_FILT: prdata <= {16'h0000, filt};
          ADDR_ISTAT: prdata <= {30'h0, istat};
          ADDR_IMASK: prdata <= {30'h0, imask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Outputs toward the pin and the rest of the chip
  assign compare_result = ctrl[CTRL_OUT];
  assign comparator_output_pin = ctrl[CTRL_OUT];
  assign comparator_output_pin_oe_n = !ctrl[CTRL_OE];
  assign event_trigger = evt_pulse;
  assign irq = |(istat & imask);

  chk_event_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CTRL_EVT] |=> !evt_pulse)
    else $error("event fired while flag set");
  chk_event_sets_flag: assert property (@(posedge pclk)
    disable iff (!presetn) evt_pulse |-> ctrl[CTRL_EVT])
    else $error("event pulse without flag");
  // A control write must steer the pin driver on the next cycle
  chk_pin_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_CTRL) |=>
    comparator_output_pin_oe_n == !$past(wd[CTRL_OE]))
    else $error("pin enable mismatch");
  chk_edge_off: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[CTRL_EDGE_LO +: 2] == EDGE_OFF) ##1
    (ctrl[CTRL_EDGE_LO +: 2] == EDGE_OFF) |-> !evt_pulse)
    else $error("event while edge detect off");
  // An enabled event must show on the interrupt line at once
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_pulse && imask[0]) |-> irq)
    else $error("irq level wrong");
  chk_result_track: assert property (@(posedge pclk) disable iff (!presetn)
    compare_result == $past(adj))
    else $error("result does not follow input");
  chk_plus_ground: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[CTRL_PLUS] && !avail.vref) |-> mux.plus_gnd)
    else $error("absent reference not grounded");
  chk_bypass_filter: assert property (@(posedge pclk) disable iff (!presetn)
    (!filt[FT_EN] && ctrl[CTRL_ENABLE] && !ctrl[CTRL_INV]) |-> adj == blanked)
    else $error("filter not bypassed");

  // Event path in two steps: an armed edge, then pulse plus flag
  sequence seq_edge_armed;
    edge_hit && !ctrl[CTRL_EVT];
  endsequence
  sequence seq_pulse_and_flag;
    evt_pulse && ctrl[CTRL_EVT];
  endsequence
  chk_event_fires: assert property (@(posedge pclk) disable iff (!presetn)
    seq_edge_armed |=> seq_pulse_and_flag)
    else $error("armed edge gave no event");

  // Filter output may only move on a divided tick
  chk_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (filt[FT_EN] && !div_tick) |=> $stable(filt_out))
    else $error("filter moved without a tick");
endmodule

// ==== cebf_analog_model.sv ====
// Behavioural analog comparator core behind the input multiplexers
`timescale 1ns/10ps
module cebf_analog_model (
  input wire cebf_pkg::cebf_mux_t mux,
  input wire logic [47:0] levels,
  output logic compare_raw
);
  import cebf_pkg::*;
  logic [7:0] vp;
  logic [7:0] vm;
  // Input routing; an absent source reads as ground
  always_comb begin
    vp = mux.plus_sel ? levels[15:8] : levels[7:0];
    if (mux.plus_gnd) begin
      vp = 8'h00;
    end
    case (mux.minus_sel)
      2'h1: vm = levels[31:24];
      2'h2: vm = levels[39:32];
      2'h3: vm = levels[47:40];
      default: vm = levels[23:16];
    endcase
    if (mux.minus_gnd) begin
      vm = 8'h00;
    end
  end
  // Settling delay keeps the result unrelated to pclk
  assign #3 compare_raw = vp > vm;
endmodule

// ==== tb.sv ====
// Self-checking bench for the comparator conditioning block
`timescale 1ns/10ps
module tb;
  import cebf_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, raw, pin, pin_oe_n, res, evt, irq;
  cebf_avail_t avail = 6'h3F;
  cebf_mask_src_t msrc = '0;
  cebf_ticks_t ticks = '0;
  cebf_mux_t mux;
  logic [47:0] lv = {8'hFA, 40'h000064960A};
  int mismatches = 0;
  int cmp_count = 0;
  int ev_cnt = 0;
  cebf_block cebf_block_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_raw(raw), .avail(avail), .mask_src(msrc), .ticks(ticks),
    .mux(mux), .comparator_output_pin(pin),
    .comparator_output_pin_oe_n(pin_oe_n), .compare_result(res),
    .event_trigger(evt), .irq(irq));
  cebf_analog_model cebf_analog_model_i (.mux(mux), .levels(lv),
    .compare_raw(raw));
  always #2.5 pclk = ~pclk;
  // Event pulses counted to expose missed lockout
  always @(posedge pclk) begin
    if (evt === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
  end
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask
  // Waits a bounded time for the result to settle
  task wres(input logic e);
    int n;
    n = 0;
    while (res !== e && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(res, e);
    // Mismatch already counted by chk; stop only if still wrong
    if (res !== e) begin
      summarize();
    end
  endtask
  task setraw(input logic v);
    lv[7:0] <= v ? 8'hC8 : 8'h0A;
  endtask
  initial begin
    int pos;
    int e0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'(i * 4), 0);
      chk(rd, 0);
    end
    apb(0, 12'h018, 0);
    chk(err, 1);
    apb(1, ADDR_MSRC, 32'hFFFF);
    apb(0, ADDR_MSRC, 0);
    chk(rd, {16'h0000, MSRC_WMASK});
    $display("test registers done");
    apb(1, ADDR_CTRL, 32'h8000);
    wres(0);
    apb(1, ADDR_CTRL, 32'h8010);
    wres(1);
    apb(1, ADDR_CTRL, 32'h8013);
    wres(0);
    avail <= 6'h3E;
    wres(1);
    chk(mux.minus_gnd, 1);
    apb(1, ADDR_CTRL, 32'hE010);
    wres(0);
    chk({pin, pin_oe_n}, 2'h0);
    apb(1, ADDR_CTRL, 32'h8010);
    wres(1);
    chk(pin_oe_n, 1);
    $display("test routing done");
    apb(1, ADDR_IMASK, 1);
    for (int c = 0; c < 4; c++) begin
      apb(1, ADDR_CTRL, 32'h8000 | (c << 6));
      wres(0);
      apb(1, ADDR_ISTAT, 3);
      e0 = ev_cnt;
      setraw(1);
      wres(1);
      apb(0, ADDR_CTRL, 0);
      chk(rd[9], c[0]);
      setraw(0);
      wres(0);
      apb(0, ADDR_CTRL, 0);
      chk(rd[9], c != 0);
      chk(ev_cnt - e0, c != 0);
      chk(irq, c != 0);
    end
    apb(1, ADDR_ISTAT, 3);
    apb(1, ADDR_IMASK, 0);
    setraw(1);
    wres(1);
    chk(irq, 0);
    $display("test events done");
    apb(1, ADDR_CTRL, 32'h8000);
    apb(1, ADDR_MGATE, 32'h0042);
    for (int c = 0; c < 16; c++) begin
      if (c < 6 || c > 11) begin
        pos = c < 6 ? c + 4 : 15 - c;
        apb(1, ADDR_MSRC, c);
        msrc <= 10'h001 << pos;
        wres(0);
        msrc <= ~(10'h001 << pos);
        wres(1);
      end
    end
    msrc <= '0;
    apb(1, ADDR_MGATE, 32'h0041);
    wres(0);
    apb(1, ADDR_MSRC, 32'h000F);
    apb(1, ADDR_MGATE, 32'h0044);
    wres(0);
    msrc <= 10'h010;
    wres(1);
    apb(1, ADDR_MGATE, 32'h8044);
    msrc <= '0;
    setraw(0);
    repeat (12) @(posedge pclk);
    wres(1);
    $display("test blanking done");
    apb(1, ADDR_MGATE, 0);
    apb(1, ADDR_FILT, 32'h0008);
    wres(0);
    setraw(1);
    wres(1);
    apb(1, ADDR_FILT, 32'h000B);
    setraw(0);
    repeat (12) @(posedge pclk);
    chk(res, 1);
    wres(0);
    apb(1, ADDR_FILT, 32'h0048);
    setraw(1);
    repeat (20) @(posedge pclk);
    chk(res, 0);
    ticks.timer <= 4'h1;
    wres(1);
    ticks <= '0;
    $display("test filter done");
    summarize();
  end
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    summarize();
  end
endmodule
